//--- include/lsgm_regs.vh
// Constants of the low-supply gain manager: modes, states, step limits, timing.
// Assumes a 20 MHz system clock; all periods are timed from a one-second tick.
`ifndef LSGM_REGS_VH
`define LSGM_REGS_VH

// Low-supply schemes
`define LSGM_SCH_SHALLOW   2'h0
`define LSGM_SCH_DEEP      2'h1
`define LSGM_SCH_ADVANCED  2'h2

// Controller states
`define LSGM_ST_RUN        1'h0
`define LSGM_ST_OFF        1'h1

// Memory index of memory A
`define LSGM_MEM_A         3'h0

// Step sizes and limits
`define LSGM_INST_DB       5'h03
`define LSGM_INST_MAX      2'h2
`define LSGM_AVG_MAX       5'h12

// Clock rate and tick period
`define LSGM_CLK_HZ        20000000
`define LSGM_TICK_MS       1000
`define LSGM_TICK_CYC      ((`LSGM_CLK_HZ / 1000) * `LSGM_TICK_MS)

// Periods in seconds, counted in ticks; the low-battery repeat is also given in minutes
`define LSGM_INST_PER_S    5'h1E
`define LSGM_AVG_STEP_S    4'hA
`define LSGM_LOWBAT_MIN    5
`define LSGM_LOWBAT_S      (`LSGM_LOWBAT_MIN * 60)

`endif

//--- rtl/lsgm_tick.v
// One-second tick generator for the low-supply gain manager.
// Assumes one free-running system clock; the tick is a one-cycle pulse.
`timescale 1ns/1ps

module lsgm_tick #(
    parameter TICK_CYC = 20000000
) (
    ref_clk,
    rstn,
    tick_r
);
    input  wire        ref_clk;   // System clock
    input  wire        rstn;      // Asynchronous reset, active low
    output reg         tick_r;    // One-cycle pulse per tick period

    reg  [31:0] cnt_r;            // Cycles elapsed in this period
    wire        wrap;             // Last cycle of the period

    assign wrap = (cnt_r == TICK_CYC - 1);

    // Free-running divider; the tick is registered so it is glitch free
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            cnt_r  <= 32'h0;
            tick_r <= 1'b0;
        end else begin
            cnt_r  <= wrap ? 32'h0 : cnt_r + 32'h1;
            tick_r <= wrap;
        end
    end
endmodule // lsgm_tick

//--- rtl/lsgm_top.v
// Low-supply gain manager: mute, gain reduction, reset and resume control
// driven by supply comparators, plus periodic low-battery indicator requests.
// Assumes all comparator inputs are synchronous, debounced levels.
`timescale 1ns/1ps
`include "lsgm_regs.vh"

module lsgm_top #(
    parameter TICK_CYC = `LSGM_TICK_CYC
) (
    ref_clk,
    rstn,
    scheme,
    inst_above_095,
    inst_above_100,
    inst_above_110,
    avg_above_095,
    avg_above_110,
    supply_above_060,
    above_ramp_down,
    above_shutdown,
    below_lowbat,
    lowbat_en,
    active_mem,
    mute_r,
    out_en_r,
    hw_reset_r,
    reinit_r,
    resume_r,
    resume_mem_r,
    inst_steps_r,
    avg_steps_r,
    atten_db_r,
    lowbat_req_r
);
    input  wire        ref_clk;          // System clock, 20 MHz
    input  wire        rstn;             // Supply-monitor reset, active low
    input  wire [1:0]  scheme;           // Selected low-supply scheme
    input  wire        inst_above_095;   // Instantaneous supply above 0.95 V
    input  wire        inst_above_100;   // Instantaneous supply above 1.0 V
    input  wire        inst_above_110;   // Instantaneous supply above 1.1 V
    input  wire        avg_above_095;    // Average supply above 0.95 V
    input  wire        avg_above_110;    // Average supply above 1.1 V
    input  wire        supply_above_060; // Supply above 0.6 V reset level
    input  wire        above_ramp_down;  // Supply above control-logic ramp-down
    input  wire        above_shutdown;   // Supply above hardware shutdown level
    input  wire        below_lowbat;     // Supply below low-battery threshold
    input  wire        lowbat_en;        // Low-battery indicator enabled
    input  wire [2:0]  active_mem;       // Memory currently in use
    output reg         mute_r;           // Audio muted
    output reg         out_en_r;         // Audio output enabled
    output reg         hw_reset_r;       // Hardware reset held, device off
    output reg         reinit_r;         // Pulse: full reinitialization
    output reg         resume_r;         // Pulse: leave reset, load resume_mem_r
    output reg  [2:0]  resume_mem_r;     // Memory to load on resume
    output reg  [1:0]  inst_steps_r;     // Instantaneous 3 dB steps applied
    output reg  [4:0]  avg_steps_r;      // Average 1 dB steps applied
    output reg  [4:0]  atten_db_r;       // Total attenuation in dB
    output reg         lowbat_req_r;     // Pulse: play low-battery indicator

    // One-second tick shared by every period timer
    wire        tick;                    // One-cycle tick pulse

    // Controller state and its next value
    reg         state_r;                 // Running or held off
    reg         state_nxt;
    reg         deep_dip_r;              // Supply fell under 0.6 V while off
    reg         deep_dip_nxt;
    reg  [2:0]  saved_mem_r;             // Memory in use before reset
    reg  [2:0]  saved_mem_nxt;
    reg         sch_mute_r;              // Shallow/deep low-supply mute latch
    reg         sch_mute_nxt;

    // Instantaneous reduction tracking
    reg  [1:0]  inst_steps_nxt;
    reg         hold_r;                  // Stabilization hold-off active
    reg         hold_nxt;
    reg  [4:0]  inst_sec_r;              // Seconds into hold or period
    reg  [4:0]  inst_sec_nxt;
    reg         ok110_r;                 // Period stayed above 1.1 V so far
    reg         ok110_nxt;
    reg         ok100_r;                 // Period stayed above 1.0 V so far
    reg         ok100_nxt;

    // Average reduction tracking
    reg  [4:0]  avg_steps_nxt;
    reg         avg_mute_r;              // Muted after the last average step
    reg         avg_mute_nxt;
    reg  [3:0]  avg_sec_r;               // Seconds since last average step
    reg  [3:0]  avg_sec_nxt;

    // Low-battery indicator timing
    reg  [8:0]  lb_sec_r;                // Seconds since last request
    reg  [8:0]  lb_sec_nxt;
    reg         lb_act_r;                // Low-battery condition seen
    reg         lb_act_nxt;

    // Registered outputs, next values
    reg         mute_nxt;
    reg         out_en_nxt;
    reg         hw_reset_nxt;
    reg         reinit_nxt;
    reg         resume_nxt;
    reg  [2:0]  resume_mem_nxt;
    reg  [4:0]  atten_nxt;
    reg         lowbat_req_nxt;

    // Decoded scheme and window ends
    wire        is_adv;                  // Advanced scheme selected
    wire        is_deep;                 // Deep scheme selected
    wire        inst_per_end;            // Last tick of a 30 s window
    wire        avg_step_end;            // Last tick of a 10 s window

    // Total attenuation from both step counters
    function [4:0] lsgm_sum_db;
        input [1:0] inst;
        input [4:0] avg;
        begin
            lsgm_sum_db = inst * `LSGM_INST_DB + avg;
        end
    endfunction

    assign is_adv  = (scheme == `LSGM_SCH_ADVANCED);
    assign is_deep = (scheme == `LSGM_SCH_DEEP);
    assign inst_per_end = tick && (inst_sec_r == `LSGM_INST_PER_S - 5'h01);
    assign avg_step_end = tick && (avg_sec_r == `LSGM_AVG_STEP_S - 4'h1);

    lsgm_tick #(
        .TICK_CYC (TICK_CYC)
    ) u_tick (
        .ref_clk  (ref_clk),
        .rstn     (rstn),
        .tick_r   (tick)
    );

    // Reset, mute and resume sequencing for all schemes
    always @* begin
        state_nxt      = state_r;
        deep_dip_nxt   = deep_dip_r;
        saved_mem_nxt  = saved_mem_r;
        sch_mute_nxt   = sch_mute_r;
        reinit_nxt     = 1'b0;
        resume_nxt     = 1'b0;
        resume_mem_nxt = resume_mem_r;
        case (state_r)
            `LSGM_ST_RUN: begin
                // Track the memory so a shallow reset can come back to it
                saved_mem_nxt = active_mem;
                if (is_deep) begin
                    if (!inst_above_095)
                        sch_mute_nxt = 1'b1;
                    if (!supply_above_060) begin
                        state_nxt    = `LSGM_ST_OFF;
                        deep_dip_nxt = 1'b1;
                    end
                end else if (is_adv) begin
                    sch_mute_nxt = 1'b0;
                    if (!above_shutdown) begin
                        state_nxt    = `LSGM_ST_OFF;
                        deep_dip_nxt = !supply_above_060;
                    end
                end else begin
                    if (!inst_above_095)
                        sch_mute_nxt = 1'b1;
                    else if (inst_above_110)
                        sch_mute_nxt = 1'b0;
                    if (!above_ramp_down) begin
                        state_nxt    = `LSGM_ST_OFF;
                        deep_dip_nxt = !supply_above_060;
                    end
                end
            end
            `LSGM_ST_OFF: begin
                // Any dip under 0.6 V while off loses the saved memory
                if (!supply_above_060)
                    deep_dip_nxt = 1'b1;
                if (inst_above_110 && supply_above_060) begin
                    state_nxt    = `LSGM_ST_RUN;
                    sch_mute_nxt = 1'b0;
                    resume_nxt   = 1'b1;
                    deep_dip_nxt = 1'b0;
                    if (deep_dip_r || is_deep) begin
                        reinit_nxt     = 1'b1;
                        resume_mem_nxt = `LSGM_MEM_A;
                    end else begin
                        resume_mem_nxt = saved_mem_r;
                    end
                end
            end
            default: begin
                state_nxt = `LSGM_ST_OFF;
            end
        endcase
    end

    // Instantaneous reductions: steps, hold-off and monitoring windows
    always @* begin
        inst_steps_nxt = inst_steps_r;
        hold_nxt       = hold_r;
        inst_sec_nxt   = inst_sec_r;
        ok110_nxt      = ok110_r;
        ok100_nxt      = ok100_r;
        if (!is_adv || state_r == `LSGM_ST_OFF) begin
            // Other schemes and the off state carry no reductions
            inst_steps_nxt = 2'h0;
            hold_nxt       = 1'b0;
            inst_sec_nxt   = 5'h00;
            ok110_nxt      = 1'b1;
            ok100_nxt      = 1'b1;
        end else if (hold_r) begin
            if (tick)
                inst_sec_nxt = inst_sec_r + 5'h01;
            if (inst_per_end) begin
                hold_nxt     = 1'b0;
                inst_sec_nxt = 5'h00;
                ok110_nxt    = 1'b1;
                ok100_nxt    = 1'b1;
            end
        end else begin
            if (tick)
                inst_sec_nxt = inst_sec_r + 5'h01;
            // Any excursion this period spoils the restore checks
            if (!inst_above_110)
                ok110_nxt = 1'b0;
            if (!inst_above_100)
                ok100_nxt = 1'b0;
            if (!inst_above_095 && avg_above_095 && inst_steps_r < `LSGM_INST_MAX) begin
                inst_steps_nxt = inst_steps_r + 2'h1;
                hold_nxt       = 1'b1;
                inst_sec_nxt   = 5'h00;
            end else if (inst_per_end) begin
                inst_sec_nxt = 5'h00;
                ok110_nxt    = 1'b1;
                ok100_nxt    = 1'b1;
                if (ok110_r && inst_above_110)
                    inst_steps_nxt = 2'h0;
                else if (ok100_r && inst_above_100 && inst_steps_r == `LSGM_INST_MAX)
                    inst_steps_nxt = 2'h1;
            end
        end
    end

    // Average reductions: 1 dB every 10 s down or up; own counter
    always @* begin
        avg_steps_nxt = avg_steps_r;
        avg_mute_nxt  = avg_mute_r;
        avg_sec_nxt   = avg_sec_r;
        if (!is_adv || state_r == `LSGM_ST_OFF) begin
            avg_steps_nxt = 5'h00;
            avg_mute_nxt  = 1'b0;
            avg_sec_nxt   = 4'h0;
        end else if (!avg_above_095) begin
            avg_sec_nxt = avg_step_end ? 4'h0 : avg_sec_r + {3'h0, tick};
            if (avg_step_end && avg_steps_r < `LSGM_AVG_MAX) begin
                avg_steps_nxt = avg_steps_r + 5'h01;
                if (avg_steps_r == `LSGM_AVG_MAX - 5'h01)
                    avg_mute_nxt = 1'b1;
            end
        end else if (avg_above_110) begin
            if (avg_mute_r) begin
                avg_mute_nxt = 1'b0;
                avg_sec_nxt  = 4'h0;
            end else begin
                avg_sec_nxt = avg_step_end ? 4'h0 : avg_sec_r + {3'h0, tick};
                if (avg_step_end && avg_steps_r != 5'h00)
                    avg_steps_nxt = avg_steps_r - 5'h01;
            end
        end else begin
            avg_sec_nxt = 4'h0;
        end
    end

    // Low-battery requests: first on entry, then every five minutes
    always @* begin
        lb_act_nxt     = lb_act_r;
        lb_sec_nxt     = lb_sec_r;
        lowbat_req_nxt = 1'b0;
        if (!lowbat_en || !below_lowbat || state_r == `LSGM_ST_OFF) begin
            // Shutdown or recovery ends the repeats
            lb_act_nxt = 1'b0;
            lb_sec_nxt = 9'h000;
        end else if (!lb_act_r) begin
            lb_act_nxt     = 1'b1;
            lb_sec_nxt     = 9'h000;
            lowbat_req_nxt = 1'b1;
        end else if (tick) begin
            if (lb_sec_r == `LSGM_LOWBAT_S - 1) begin
                lb_sec_nxt     = 9'h000;
                lowbat_req_nxt = 1'b1;
            end else begin
                lb_sec_nxt = lb_sec_r + 9'h001;
            end
        end
    end

    // Output decode from the next state so every output is a flop
    always @* begin
        out_en_nxt   = (state_nxt == `LSGM_ST_RUN);
        hw_reset_nxt = (state_nxt == `LSGM_ST_OFF);
        mute_nxt     = !out_en_nxt || sch_mute_nxt || avg_mute_nxt;
        atten_nxt    = lsgm_sum_db(inst_steps_nxt, avg_steps_nxt);
    end

    // State registers; power-up behaves as a deep dip so memory A loads
    always @(posedge ref_clk or negedge rstn) begin
        if (!rstn) begin
            state_r      <= `LSGM_ST_OFF;
            deep_dip_r   <= 1'b1;
            saved_mem_r  <= `LSGM_MEM_A;
            sch_mute_r   <= 1'b0;
            hold_r       <= 1'b0;
            inst_sec_r   <= 5'h00;
            ok110_r      <= 1'b1;
            ok100_r      <= 1'b1;
            avg_mute_r   <= 1'b0;
            avg_sec_r    <= 4'h0;
            lb_act_r     <= 1'b0;
            lb_sec_r     <= 9'h000;
            mute_r       <= 1'b1;
            out_en_r     <= 1'b0;
            hw_reset_r   <= 1'b1;
            reinit_r     <= 1'b0;
            resume_r     <= 1'b0;
            resume_mem_r <= `LSGM_MEM_A;
            inst_steps_r <= 2'h0;
            avg_steps_r  <= 5'h00;
            atten_db_r   <= 5'h00;
            lowbat_req_r <= 1'b0;
        end else begin
            state_r      <= state_nxt;
            deep_dip_r   <= deep_dip_nxt;
            saved_mem_r  <= saved_mem_nxt;
            sch_mute_r   <= sch_mute_nxt;
            hold_r       <= hold_nxt;
            inst_sec_r   <= inst_sec_nxt;
            ok110_r      <= ok110_nxt;
            ok100_r      <= ok100_nxt;
            avg_mute_r   <= avg_mute_nxt;
            avg_sec_r    <= avg_sec_nxt;
            lb_act_r     <= lb_act_nxt;
            lb_sec_r     <= lb_sec_nxt;
            mute_r       <= mute_nxt;
            out_en_r     <= out_en_nxt;
            hw_reset_r   <= hw_reset_nxt;
            reinit_r     <= reinit_nxt;
            resume_r     <= resume_nxt;
            resume_mem_r <= resume_mem_nxt;
            inst_steps_r <= inst_steps_nxt;
            avg_steps_r  <= avg_steps_nxt;
            atten_db_r   <= atten_nxt;
            lowbat_req_r <= lowbat_req_nxt;
        end
    end
endmodule // lsgm_top

//--- dv/lsgm_checker.sv
// Assertion checker for the low-supply gain manager, bound to its top module.
// Assumes the bench resets the block whenever it changes the scheme.
`timescale 1ns/1ps
`include "lsgm_regs.vh"

module lsgm_checker #(
    parameter TICK_CYC = 10      // Tick length, handed on by the bind
) (
    input wire       ref_clk,
    input wire       rstn,
    input wire [1:0] scheme,
    input wire       inst_above_095,
    input wire       inst_above_110,
    input wire       avg_above_095,
    input wire       avg_above_110,
    input wire       supply_above_060,
    input wire       above_ramp_down,
    input wire       above_shutdown,
    input wire       below_lowbat,
    input wire       lowbat_en,
    input wire       mute_r,
    input wire       out_en_r,
    input wire       hw_reset_r,
    input wire       reinit_r,
    input wire       resume_r,
    input wire [2:0] resume_mem_r,
    input wire [1:0] inst_steps_r,
    input wire [4:0] avg_steps_r,
    input wire [4:0] atten_db_r,
    input wire       lowbat_req_r
);
    // One clock domain; every check sleeps while reset is held
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rstn);

    off_cause_a:
        assert property ($fell(out_en_r) |-> hw_reset_r && $past(scheme == `LSGM_SCH_DEEP ? !supply_above_060 :
                         scheme == `LSGM_SCH_ADVANCED ? !above_shutdown : !above_ramp_down))
        else $error("device went off without its supply cause");
    resume_cause_a:
        assert property ($rose(out_en_r) |-> resume_r && $past(inst_above_110 && supply_above_060))
        else $error("device left off state without a good supply");
    reinit_mem_a:
        assert property (reinit_r |-> resume_r && resume_mem_r == `LSGM_MEM_A)
        else $error("reinitialization without memory A");
    deep_reinit_a:
        assert property (resume_r && scheme == `LSGM_SCH_DEEP |-> reinit_r)
        else $error("deep scheme resumed without reinitialization");
    shallow_mute_a:
        assert property (scheme == `LSGM_SCH_SHALLOW && out_en_r && above_ramp_down && !inst_above_095 |=> mute_r)
        else $error("shallow dip did not mute");
    mute_hold_a:
        assert property ((scheme == `LSGM_SCH_SHALLOW || scheme == `LSGM_SCH_DEEP) && out_en_r && mute_r
                         && !inst_above_110 |=> mute_r)
        else $error("mute released too early");
    inst_step_a:
        assert property (inst_steps_r > $past(inst_steps_r) |-> inst_steps_r == $past(inst_steps_r) + 2'h1
                         && $past(!inst_above_095 && avg_above_095) && inst_steps_r <= `LSGM_INST_MAX)
        else $error("instantaneous step without a dip");
    avg_dir_a:
        assert property (out_en_r && $past(out_en_r) && avg_steps_r != $past(avg_steps_r) |->
                         ($past(avg_above_095) ? $past(avg_above_110) && avg_steps_r == $past(avg_steps_r) - 5'h01
                          : avg_steps_r == $past(avg_steps_r) + 5'h01 && avg_steps_r <= `LSGM_AVG_MAX))
        else $error("average steps moved the wrong way");
    avg_mute_a:
        assert property ($rose(avg_steps_r == `LSGM_AVG_MAX) |-> ##[0:1] mute_r)
        else $error("full average reduction without mute");
    unmute_a:
        assert property (scheme == `LSGM_SCH_ADVANCED && out_en_r && mute_r && avg_above_110 && inst_above_110
                         |=> !mute_r)
        else $error("high average did not unmute");
    atten_sum_a:
        assert property (atten_db_r == 5'h03 * inst_steps_r + avg_steps_r)
        else $error("attenuation is not the sum of the steps");
    lowbat_pulse_a:
        assert property (lowbat_req_r |-> $past(lowbat_en && below_lowbat) ##1 !lowbat_req_r)
        else $error("low-battery request without cause or too long");
    scheme_only_a:
        assert property (scheme != `LSGM_SCH_ADVANCED |-> inst_steps_r == 2'h0 && avg_steps_r == 5'h00)
        else $error("gain steps outside the advanced scheme");
endmodule // lsgm_checker

// Attach the checker to the top module
bind lsgm_top lsgm_checker #(.TICK_CYC(TICK_CYC)) i_lsgm_checker (
    .ref_clk, .rstn, .scheme, .inst_above_095, .inst_above_110, .avg_above_095, .avg_above_110,
    .supply_above_060, .above_ramp_down, .above_shutdown, .below_lowbat, .lowbat_en, .mute_r,
    .out_en_r, .hw_reset_r, .reinit_r, .resume_r, .resume_mem_r, .inst_steps_r, .avg_steps_r,
    .atten_db_r, .lowbat_req_r
);

//--- dv/lsgm_supply_model.sv
// Supply comparator model: turns supply levels in millivolts into comparator levels.
// Assumes the bench changes the levels on the falling clock edge only.
`timescale 1ns/1ps

module lsgm_supply_model #(
    parameter RAMP_MV = 800,     // Control-logic ramp-down level, a plain guess
    parameter SHUT_MV = 800,     // Hardware shutdown level, a plain guess
    parameter LOWB_MV = 1050     // Low-battery notification level
) (
    input  int  inst_mv,
    input  int  avg_mv,
    output wire inst_above_095,
    output wire inst_above_100,
    output wire inst_above_110,
    output wire avg_above_095,
    output wire avg_above_110,
    output wire supply_above_060,
    output wire above_ramp_down,
    output wire above_shutdown,
    output wire below_lowbat
);
    // Ideal comparators; no hysteresis, so the bench sees every crossing at once
    assign inst_above_095   = inst_mv > 950;
    assign inst_above_100   = inst_mv > 1000;
    assign inst_above_110   = inst_mv > 1100;
    assign avg_above_095    = avg_mv > 950;
    assign avg_above_110    = avg_mv > 1100;
    assign supply_above_060 = inst_mv > 600;
    assign above_ramp_down  = inst_mv > RAMP_MV;
    assign above_shutdown   = inst_mv > SHUT_MV;
    assign below_lowbat     = inst_mv < LOWB_MV;
endmodule // lsgm_supply_model

//--- dv/testbench.sv
// Self-checking bench for the low-supply gain manager with a comparator model.
// Assumes a short tick so that the long periods fit in the run.
`timescale 1ns/1ps
`include "lsgm_regs.vh"

module testbench;
    localparam TK = 10;                  // Cycles per tick in simulation
    reg        ref_clk, rstn, lowbat_en; // Clock, reset and indicator enable
    reg [1:0]  scheme;                   // Selected scheme
    reg [2:0]  active_mem, m, rs_mem;    // Memory in use, its copy, memory seen on resume
    reg        rs_init;                  // Reinit seen with the last resume
    int        inst_mv, avg_mv;          // Supply levels for the model
    int        errors, check_count, cyc, w, k, lb_cnt, lb_gap, lb_last, rs_cnt;
    wire       i95, i100, i110, a95, a110, s60, ramp, shut, lowb;
    wire       mute_r, out_en_r, hw_reset_r, reinit_r, resume_r, lowbat_req_r;
    wire [2:0] resume_mem_r;
    wire [1:0] inst_steps_r;
    wire [4:0] avg_steps_r, atten_db_r;

    lsgm_supply_model i_lsgm_supply_model (.inst_mv(inst_mv), .avg_mv(avg_mv), .inst_above_095(i95),
        .inst_above_100(i100), .inst_above_110(i110), .avg_above_095(a95), .avg_above_110(a110),
        .supply_above_060(s60), .above_ramp_down(ramp), .above_shutdown(shut), .below_lowbat(lowb));
    lsgm_top #(.TICK_CYC(TK)) i_lsgm_top (.ref_clk(ref_clk), .rstn(rstn), .scheme(scheme),
        .inst_above_095(i95), .inst_above_100(i100), .inst_above_110(i110), .avg_above_095(a95),
        .avg_above_110(a110), .supply_above_060(s60), .above_ramp_down(ramp), .above_shutdown(shut),
        .below_lowbat(lowb), .lowbat_en(lowbat_en), .active_mem(active_mem), .mute_r(mute_r),
        .out_en_r(out_en_r), .hw_reset_r(hw_reset_r), .reinit_r(reinit_r), .resume_r(resume_r),
        .resume_mem_r(resume_mem_r), .inst_steps_r(inst_steps_r), .avg_steps_r(avg_steps_r),
        .atten_db_r(atten_db_r), .lowbat_req_r(lowbat_req_r));

    // Clock generator
    initial begin
        ref_clk = 1'b0;
        forever #25 ref_clk = ~ref_clk;
    end

    // One-cycle pulses are caught at the edge, before that edge updates them
    always @(posedge ref_clk) begin
        cyc = cyc + 1;
        if (resume_r === 1'b1) begin
            rs_cnt = rs_cnt + 1;
            rs_mem = resume_mem_r;
            rs_init = reinit_r;
        end
        if (lowbat_req_r === 1'b1) begin
            lb_gap = cyc - lb_last;
            lb_last = cyc;
            lb_cnt = lb_cnt + 1;
        end
    end

    // Expected total attenuation
    function [4:0] exp_atten(input [1:0] i, input [4:0] a);
        exp_atten = {3'h0, i} * 5'h03 + a;
    endfunction

    // Expected reinit flag and memory after a stay in the off state
    function [3:0] exp_mem(input low, input [2:0] mem);
        exp_mem = {low, low ? `LSGM_MEM_A : mem};
    endfunction

    // Compare and count
    task chk(input [7:0] seen, input [7:0] exp, input string msg);
        check_count = check_count + 1;
        if (seen !== exp) begin
            errors = errors + 1;
            $display("CHECK FAILED at %0t: %0s", $time, msg);
        end
    endtask

    task step(input int n);
        repeat (n) @(negedge ref_clk);
    endtask

    // Reset 16 cycles in a scheme, then power up
    task power(input [1:0] sch);
        rstn = 1'b0;
        scheme = sch;
        inst_mv = 1200;
        avg_mv = 1200;
        step(16);
        chk({mute_r, out_en_r, hw_reset_r, atten_db_r}, 8'hA0, "reset values");
        rstn = 1'b1;
        k = rs_cnt;
        step(3);
        chk(rs_cnt - k, 8'h01, "power-up resume");
        chk({rs_init, rs_mem, mute_r, out_en_r}, 8'h21, "power-up from memory A");
    endtask

    // Dip, sit off above 0.6 V, recover above 1.1 V
    task offon(input int lo, input [3:0] exp);
        inst_mv = lo;
        step(3);
        chk({hw_reset_r, out_en_r}, 8'h02, "off after dip");
        inst_mv = 1000;
        step(20);
        chk(out_en_r, 8'h00, "off until 1.1 V");
        k = rs_cnt;
        inst_mv = 1200;
        step(3);
        chk(rs_cnt - k, 8'h01, "resume pulse");
        chk({rs_init, rs_mem}, exp, "resume memory");
    endtask

    task summarize;
        if (errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // Watchdog well beyond the expected run
    initial begin
        #(50 * 40000);
        errors = errors + 1;
        summarize;
    end

    // Main sequence
    initial begin
        {errors, check_count, cyc, lb_cnt, lb_gap, lb_last, rs_cnt} = 0;
        {lowbat_en, rs_init, rs_mem, scheme} = 0;
        w = $urandom(32'hFFD6);
        m = 3'h1 + 3'($urandom % 5);
        active_mem = m;
        power(`LSGM_SCH_SHALLOW);
        inst_mv = 810 + $urandom % 130;
        step(2);
        chk(mute_r, 8'h01, "shallow dip mutes");
        inst_mv = 1050;
        step(5);
        chk(mute_r, 8'h01, "mute held below 1.1 V");
        inst_mv = 1200;
        step(2);
        chk(mute_r, 8'h00, "unmute above 1.1 V");
        offon(610 + $urandom % 180, exp_mem(1'b0, m));
        offon(500 - $urandom % 200, exp_mem(1'b1, m));
        power(`LSGM_SCH_DEEP);
        inst_mv = 700;
        step(3);
        chk({out_en_r, mute_r}, 8'h03, "deep mutes but stays on");
        inst_mv = 1200;
        step(3);
        chk(mute_r, 8'h01, "deep mute held");
        offon(500, exp_mem(1'b1, m));
        power(`LSGM_SCH_ADVANCED);
        inst_mv = 900;
        step(1);
        chk(atten_db_r, exp_atten(2'h1, 5'h00), "first 3 dB step");
        inst_mv = 1200;
        step(100);
        inst_mv = 900;
        step(1);
        chk(inst_steps_r, 8'h01, "dip ignored in hold");
        inst_mv = 1200;
        step(220);
        inst_mv = 900;
        step(1);
        chk(atten_db_r, exp_atten(2'h2, 5'h00), "second 3 dB step");
        inst_mv = 1050;
        for (w = 0; w < 700 && inst_steps_r !== 2'h1; w++) step(1);
        chk(atten_db_r, exp_atten(2'h1, 5'h00), "back to one step");
        inst_mv = 1200;
        for (w = 0; w < 700 && inst_steps_r !== 2'h0; w++) step(1);
        chk(inst_steps_r, 8'h00, "all steps removed");
        avg_mv = 900;
        for (w = 0; w < 520 && avg_steps_r !== 5'h05; w++) step(1);
        for (w = 0; w < 120 && avg_steps_r !== 5'h06; w++) step(1);
        chk(w, 8'd100, "10 s between average steps");
        {avg_mv, inst_mv} = {32'h3E8, 32'h384};
        step(1);
        {avg_mv, inst_mv} = {32'h384, 32'h4B0};
        chk(atten_db_r, exp_atten(2'h1, 5'h06), "counters independent");
        for (w = 0; w < 1300 && avg_steps_r !== `LSGM_AVG_MAX; w++) step(1);
        step(2);
        chk({mute_r, avg_steps_r}, 8'h32, "mute after 18 steps");
        avg_mv = 1000;
        step(300);
        chk({mute_r, avg_steps_r}, 8'h32, "middle band holds");
        avg_mv = 1200;
        step(1);
        chk(mute_r, 8'h00, "unmute first");
        for (w = 0; w < 1900 && avg_steps_r !== 5'h00; w++) step(1);
        chk(avg_steps_r, 8'h00, "average steps removed");
        offon(700, exp_mem(1'b0, m));
        lowbat_en = 1'b1;
        inst_mv = 1000;
        k = lb_cnt;
        step(2);
        chk(lb_cnt - k, 8'h01, "first low-battery request");
        for (w = 0; w < 3100 && lb_cnt - k < 2; w++) step(1);
        chk(lb_gap >= 2990 && lb_gap <= 3000, 8'h01, "five-minute repeat");
        lowbat_en = 1'b0;
        k = lb_cnt;
        step(3100);
        chk(lb_cnt - k, 8'h00, "no request when disabled");
        summarize;
    end
endmodule // testbench
